/* File: rtl/fwrc_pkg.sv */
// package for the fault and warning report controller
// assumes: one 40 MHz clock, classic wishbone register access
package fwrc_pkg;
    // byte addresses are four times the printed register index
    localparam logic [7:0] FWRC_IDX_WARN    = 8'h73;
    localparam logic [7:0] FWRC_IDX_MASK1   = 8'h74;
    localparam logic [7:0] FWRC_IDX_MASK2   = 8'h75;
    localparam logic [7:0] FWRC_IDX_MISC    = 8'h76;
    localparam logic [7:0] FWRC_IDX_CBC     = 8'h77;
    localparam logic [7:0] FWRC_IDX_CLEAR   = 8'h78;
    localparam logic [7:0] FWRC_IDX_FAULT   = 8'h79;
    localparam logic [7:0] FWRC_IDX_IRQ_ST  = 8'h7a;
    localparam logic [7:0] FWRC_IDX_IRQ_MSK = 8'h7b;
    localparam int FWRC_ADDR_W = 10;
    // reset values
    localparam logic [7:0] FWRC_RST_MASK1 = 8'h00;
    localparam logic [7:0] FWRC_RST_MASK2 = 8'hf8;
    localparam logic [7:0] FWRC_RST_MISC  = 8'h00;
    localparam logic [7:0] FWRC_RST_CBC   = 8'h00;
    localparam logic [7:0] FWRC_RST_IRQM  = 8'h00;
    // writable bits of the first mask register (bit 3 reserved)
    localparam logic [7:0] FWRC_MASK1_WR  = 8'hf7;
    // first mask register fields
    localparam int FWRC_M1_OTSD = 7;
    localparam int FWRC_M1_DUV  = 6;
    localparam int FWRC_M1_DOV  = 5;
    localparam int FWRC_M1_CLK  = 4;
    localparam int FWRC_M1_PVDD = 2;
    localparam int FWRC_M1_DC   = 1;
    localparam int FWRC_M1_OC   = 0;
    // second mask register fields
    localparam int FWRC_M2_CBCF_LAT = 7;
    localparam int FWRC_M2_CBCW_LAT = 6;
    localparam int FWRC_M2_CLK_LAT  = 5;
    localparam int FWRC_M2_OTSD_LAT = 4;
    localparam int FWRC_M2_OTW_LAT  = 3;
    localparam int FWRC_M2_OTW_MSK  = 2;
    localparam int FWRC_M2_CBCW_MSK = 1;
    localparam int FWRC_M2_CBCF_MSK = 0;
    // misc and current limit fields
    localparam int FWRC_MISC_DETLAT = 7;
    localparam int FWRC_MISC_AUTOREC = 4;
    localparam int FWRC_CBC_FUNC = 2;
    localparam int FWRC_CBC_WARN = 1;
    localparam int FWRC_CBC_FAULT = 0;
    localparam int FWRC_CLR_ANALOG = 7;
    // warning status fields
    localparam int FWRC_W_LEFT  = 5;
    localparam int FWRC_W_RIGHT = 4;
    localparam int FWRC_W_OTW0  = 0;
    localparam int FWRC_OTW_LEVELS = 4;
    // fault status fields (own register)
    localparam int FWRC_F_DUV  = 0;
    localparam int FWRC_F_DOV  = 1;
    localparam int FWRC_F_PUV  = 2;
    localparam int FWRC_F_POV  = 3;
    localparam int FWRC_F_CLK  = 4;
    localparam int FWRC_F_OTSD = 5;
    localparam int FWRC_F_CBC  = 6;
    localparam int FWRC_F_DC   = 7;
    localparam int FWRC_NFLT   = 8;
    localparam logic [7:0] FWRC_ANALOG_FLT = 8'h3f;
    // interrupt status bits
    localparam int FWRC_I_FAULT = 0;
    localparam int FWRC_I_WARN  = 1;
    localparam int FWRC_I_OC    = 2;
endpackage

/* File: rtl/fwrc_bus_if.sv */
// carrier between the wishbone slave and the register core
// assumes: both ends on SYS_CLK_IN
`timescale 1ns/1ps
interface fwrc_bus_if;
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slave (output wr, output rd, output idx, output wdata,
                   input rdata);
    modport core  (input wr, input rd, input idx, input wdata,
                   output rdata);
endinterface

/* File: rtl/fwrc_wb_slave.sv */
// classic wishbone slave: one-wait ack, byte lane 0 only
// assumes: master holds the request until ack
`timescale 1ns/1ps
module fwrc_wb_slave
    import fwrc_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   arst_n_in,
    input  wire logic                   ce_in,
    input  wire logic                   cyc_in,
    input  wire logic                   stb_in,
    input  wire logic                   we_in,
    input  wire logic [3:0]             sel_in,
    input  wire logic [FWRC_ADDR_W-1:0] adr_in,
    input  wire logic [31:0]            dat_in,
    output logic                        ack_out,
    output logic [31:0]                 dat_out,
    fwrc_bus_if.slave                   bus
);
    wire req = cyc_in & stb_in & ~ack_out;

    assign bus.idx   = adr_in[FWRC_ADDR_W-1:2];
    assign bus.wdata = dat_in[7:0];
    // strobes fire on the cycle ack rises, once per access
    assign bus.wr    = ce_in & req & we_in & sel_in[0];
    assign bus.rd    = ce_in & req & ~we_in;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_out <= 1'b0;
            dat_out <= 32'h0000_0000;
        end else if (ce_in) begin
            ack_out <= req;
            // data moves only with an answer
            if (req)
                dat_out <= {24'h00_0000, bus.rdata};
        end
    end
endmodule

/* File: rtl/fwrc_top.sv */
// fault and warning report controller: registers, latching, reporting
// assumes: fault inputs are asynchronous levels from analog monitors
`timescale 1ns/1ps
// Operation
// - left overcurrent warning sets status bit 5, right sets bit 4.
// - temperature level one (112C) sets bit 0, level two (122C) bit 1.
// - temperature level three (134C) sets bit 2, level four (146C) bit 3.
// - mask bit 7 hides the overtemperature shutdown fault; reported by default.
// - bit 6 hides digital undervoltage, bit 5 digital overvoltage fault.
// - bit 4 hides the clock fault report.
// - bit 2 hides both power supply under and overvoltage faults.
// - bit 1 hides the dc fault, bit 0 the overcurrent fault.
// - second register bits 7 and 6 latch cycle limit fault and warning.
// - second register bit 5 latches the clock fault, reset one.
// - bit 4 latches shutdown fault, bit 3 temperature warning, reset one.
// - bits 2, 1, 0 hide temperature warn, cycle warn, cycle fault.
// - misc bit 7 selects latched or live clock detection status.
// - misc bit 4 enables shutdown auto recovery, reset zero.
// - writing one to clear bit 7 clears latched analog faults.
// - supply, clock, temperature faults set flag, hi-z output, report pin.
// - latched analog fault flag stays one until clear bit 7 written.
module fwrc_top
    import fwrc_pkg::*;
#(
    parameter int SYNC_STAGES = 2
)(
    input  wire logic                   SYS_CLK_IN,
    input  wire logic                   ARST_N_IN,
    input  wire logic                   CE_IN,
    input  wire logic                   WB_CYC_IN,
    input  wire logic                   WB_STB_IN,
    input  wire logic                   WB_WE_IN,
    input  wire logic [3:0]             WB_SEL_IN,
    input  wire logic [FWRC_ADDR_W-1:0] WB_ADR_IN,
    input  wire logic [31:0]            WB_DAT_IN,
    input  wire logic                   LEFT_CYCLE_LIMIT_WARN_IN,
    input  wire logic                   RIGHT_CYCLE_LIMIT_WARN_IN,
    input  wire logic [3:0]             TEMP_WARN_LEVEL_IN,
    input  wire logic                   OVERTEMP_SHUTDOWN_IN,
    input  wire logic                   DIGITAL_SUPPLY_UNDER_IN,
    input  wire logic                   DIGITAL_SUPPLY_OVER_IN,
    input  wire logic                   POWER_SUPPLY_UNDER_IN,
    input  wire logic                   POWER_SUPPLY_OVER_IN,
    input  wire logic                   CLOCK_FAULT_IN,
    input  wire logic                   DC_FAULT_IN,
    input  wire logic                   OVERCURRENT_IN,
    input  wire logic                   CYCLE_LIMIT_FAULT_IN,
    input  wire logic                   CLOCK_DETECT_IN,
    output logic                        WB_ACK_OUT,
    output logic [31:0]                 WB_DAT_OUT,
    output logic                        FAULT_REPORT_N_OUT,
    output logic                        OUTPUT_HIZ_OUT,
    output logic                        CLOCK_DETECT_STATUS_OUT,
    output logic                        AUTO_RECOVER_EN_OUT,
    output logic                        CYCLE_LIMIT_FUNC_EN_OUT,
    output logic                        IRQ_OUT
);
    // only a two-flop chain is built
    if (SYNC_STAGES != 2) begin : g_bad_sync
        $error("SYNC_STAGES must be 2");
    end

    localparam int NIN = 16;

    // ---- input synchronisers ----
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] sync_a;
    logic [NIN-1:0] sync_b;
    assign raw_in = {
        CLOCK_DETECT_IN,
        CYCLE_LIMIT_FAULT_IN,
        OVERCURRENT_IN,
        DC_FAULT_IN,
        CLOCK_FAULT_IN,
        POWER_SUPPLY_OVER_IN,
        POWER_SUPPLY_UNDER_IN,
        DIGITAL_SUPPLY_OVER_IN,
        DIGITAL_SUPPLY_UNDER_IN,
        OVERTEMP_SHUTDOWN_IN,
        TEMP_WARN_LEVEL_IN,
        RIGHT_CYCLE_LIMIT_WARN_IN,
        LEFT_CYCLE_LIMIT_WARN_IN
    };

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
                if (!ARST_N_IN) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else if (CE_IN) begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    wire       s_left    = sync_b[0];
    wire       s_right   = sync_b[1];
    wire [3:0] s_temp    = sync_b[5:2];

    wire       s_otsd    = sync_b[6];
    wire       s_duv     = sync_b[7];
    wire       s_dov     = sync_b[8];
    wire       s_puv     = sync_b[9];
    wire       s_pov     = sync_b[10];
    wire       s_clk     = sync_b[11];
    wire       s_dc      = sync_b[12];
    wire       s_oc      = sync_b[13];
    wire       s_cbcf    = sync_b[14];
    wire       s_clkdet  = sync_b[15];

    // ---- register bus ----
    fwrc_bus_if bus ();

    fwrc_wb_slave u_wb (
        .clk_in    (SYS_CLK_IN),
        .arst_n_in (ARST_N_IN),
        .ce_in     (CE_IN),
        .cyc_in    (WB_CYC_IN),
        .stb_in    (WB_STB_IN),
        .we_in     (WB_WE_IN),
        .sel_in    (WB_SEL_IN),
        .adr_in    (WB_ADR_IN),
        .dat_in    (WB_DAT_IN),
        .ack_out   (WB_ACK_OUT),
        .dat_out   (WB_DAT_OUT),
        .bus       (bus)
    );

    logic [7:0] fault_report_mask;
    logic [7:0] latch_and_warning_mask;
    logic [7:0] misc_fault_control;
    logic [7:0] current_limit_control;
    logic [7:0] warning_status;
    logic [7:0] fault_status;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic       clock_detect_held;

    wire wr_mask1 = bus.wr & (bus.idx == FWRC_IDX_MASK1);
    wire wr_mask2 = bus.wr & (bus.idx == FWRC_IDX_MASK2);
    wire wr_misc  = bus.wr & (bus.idx == FWRC_IDX_MISC);
    wire wr_cbc   = bus.wr & (bus.idx == FWRC_IDX_CBC);
    wire wr_irqm  = bus.wr & (bus.idx == FWRC_IDX_IRQ_MSK);
    wire rd_irqs  = bus.rd & (bus.idx == FWRC_IDX_IRQ_ST);
    // write-only strobe, nothing stored
    wire analog_clear = bus.wr & (bus.idx == FWRC_IDX_CLEAR)
                        & bus.wdata[FWRC_CLR_ANALOG];

    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            fault_report_mask      <= FWRC_RST_MASK1;
            latch_and_warning_mask <= FWRC_RST_MASK2;
            misc_fault_control     <= FWRC_RST_MISC;
            current_limit_control  <= FWRC_RST_CBC;
            irq_mask               <= FWRC_RST_IRQM[2:0];
        end else if (CE_IN) begin
            if (wr_mask1)
                fault_report_mask <= bus.wdata & FWRC_MASK1_WR;
            if (wr_mask2)
                latch_and_warning_mask <= bus.wdata;
            if (wr_misc)
                misc_fault_control <= bus.wdata;
            if (wr_cbc)
                current_limit_control <= bus.wdata;
            if (wr_irqm)
                irq_mask <= bus.wdata[2:0];
        end
    end

    wire m_otsd = fault_report_mask[FWRC_M1_OTSD];
    wire m_duv  = fault_report_mask[FWRC_M1_DUV];
    wire m_dov  = fault_report_mask[FWRC_M1_DOV];
    wire m_clk  = fault_report_mask[FWRC_M1_CLK];
    wire m_pvdd = fault_report_mask[FWRC_M1_PVDD];
    wire m_dc   = fault_report_mask[FWRC_M1_DC];
    wire m_oc   = fault_report_mask[FWRC_M1_OC];

    wire l_cbcf = latch_and_warning_mask[FWRC_M2_CBCF_LAT];
    wire l_cbcw = latch_and_warning_mask[FWRC_M2_CBCW_LAT];
    wire l_clk  = latch_and_warning_mask[FWRC_M2_CLK_LAT];
    wire l_otsd = latch_and_warning_mask[FWRC_M2_OTSD_LAT];
    wire l_otw  = latch_and_warning_mask[FWRC_M2_OTW_LAT];
    wire m_otw  = latch_and_warning_mask[FWRC_M2_OTW_MSK];
    wire m_cbcw = latch_and_warning_mask[FWRC_M2_CBCW_MSK];
    wire m_cbcf = latch_and_warning_mask[FWRC_M2_CBCF_MSK];

    wire auto_rec = misc_fault_control[FWRC_MISC_AUTOREC];
    wire cbc_func = current_limit_control[FWRC_CBC_FUNC];
    wire cbc_warn = current_limit_control[FWRC_CBC_WARN];
    wire cbc_flt  = current_limit_control[FWRC_CBC_FAULT];

    // ---- live conditions and latch enables per flag ----
    // shutdown clears by itself when auto recovery is on or its latch bit is zero
    wire [7:0] live_flt = {
        s_dc,
        s_cbcf & cbc_flt,
        s_otsd,
        s_clk,
        s_pov,
        s_puv,
        s_dov,
        s_duv
    };

    // dc stays live: no clear reaches it, a latch would stick
    wire [7:0] latch_flt = {
        1'b0,
        l_cbcf,
        l_otsd & ~auto_rec,
        l_clk,
        4'hf
    };

    wire [7:0] live_warn = {
        2'b00,
        s_left & cbc_warn,
        s_right & cbc_warn,
        s_temp
    };

    wire [7:0] latch_warn = {
        2'b00,
        l_cbcw,
        l_cbcw,
        {4{l_otw}}
    };
    wire [7:0] flt_clear  = analog_clear ? FWRC_ANALOG_FLT
                                         : 8'h00;

    // set wins over clear; unlatched bits follow the live level
    wire [7:0] next_fault_status =
        live_flt | (fault_status & latch_flt & ~flt_clear);
    wire [7:0] next_warning_status =
        live_warn | (warning_status & latch_warn & ~{8{analog_clear}});

    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            fault_status   <= 8'h00;
            warning_status <= 8'h00;
        end else if (CE_IN) begin
            fault_status   <= next_fault_status;
            warning_status <= next_warning_status;
        end
    end

    // ---- clock detection status ----
    wire next_clock_detect = misc_fault_control[FWRC_MISC_DETLAT]
                             ? (clock_detect_held | s_clkdet)
                             : s_clkdet;

    // ---- reporting ----
    wire report_flt = (fault_status[FWRC_F_OTSD] & ~m_otsd)
                    | (fault_status[FWRC_F_DUV]  & ~m_duv)
                    | (fault_status[FWRC_F_DOV]  & ~m_dov)
                    | (fault_status[FWRC_F_CLK]  & ~m_clk)
                    | ((fault_status[FWRC_F_PUV]
                        | fault_status[FWRC_F_POV]) & ~m_pvdd)
                    | (fault_status[FWRC_F_DC]   & ~m_dc)
                    | (s_oc & ~m_oc)
                    | (fault_status[FWRC_F_CBC]  & ~m_cbcf);
    wire report_warn = (|warning_status[3:0] & ~m_otw)
                     | (|warning_status[5:4] & ~m_cbcw);
    wire hiz = |fault_status[5:0] | s_oc;

    wire [2:0] irq_event = {
        s_oc,
        report_warn,
        report_flt
    };
    wire [2:0] next_irq_status =
        irq_event | (irq_status & ~{3{rd_irqs}});

    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            irq_status              <= 3'h0;
            clock_detect_held       <= 1'b0;
            FAULT_REPORT_N_OUT      <= 1'b1;
            OUTPUT_HIZ_OUT          <= 1'b0;
            CLOCK_DETECT_STATUS_OUT <= 1'b0;
            AUTO_RECOVER_EN_OUT     <= 1'b0;
            CYCLE_LIMIT_FUNC_EN_OUT <= 1'b0;
            IRQ_OUT                 <= 1'b0;
        end else if (CE_IN) begin
            irq_status              <= next_irq_status;
            clock_detect_held       <= next_clock_detect;
            FAULT_REPORT_N_OUT      <= ~(report_flt | report_warn);
            OUTPUT_HIZ_OUT          <= hiz;
            CLOCK_DETECT_STATUS_OUT <= next_clock_detect;
            AUTO_RECOVER_EN_OUT     <= auto_rec;
            CYCLE_LIMIT_FUNC_EN_OUT <= cbc_func;
            IRQ_OUT                 <= |(next_irq_status & irq_mask);
        end
    end

    // ---- read mux; unmapped indexes read zero ----
    logic [7:0] rsel;
    always_comb begin
        case (bus.idx)
            FWRC_IDX_WARN:    rsel = warning_status;
            FWRC_IDX_MASK1:   rsel = fault_report_mask;
            FWRC_IDX_MASK2:   rsel = latch_and_warning_mask;
            FWRC_IDX_MISC:    rsel = misc_fault_control;
            FWRC_IDX_CBC:     rsel = current_limit_control;
            FWRC_IDX_CLEAR:   rsel = 8'h00;
            FWRC_IDX_FAULT:   rsel = fault_status;
            FWRC_IDX_IRQ_ST:  rsel = {5'h00, irq_status};
            FWRC_IDX_IRQ_MSK: rsel = {5'h00, irq_mask};
            default:          rsel = 8'h00;
        endcase
    end
    assign bus.rdata = rsel;
endmodule

/* File: verification/fwrc_chk.sv */
// port-level checks of the fault and warning report controller
// assumes: bound into fwrc_top, one clock, async active-low reset
`timescale 1ns/1ps
module fwrc_chk (
    input wire logic        SYS_CLK_IN,
    input wire logic        ARST_N_IN,
    input wire logic        CE_IN,
    input wire logic        WB_CYC_IN,
    input wire logic        WB_STB_IN,
    input wire logic        WB_ACK_OUT,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic        OVERTEMP_SHUTDOWN_IN,
    input wire logic        CLOCK_FAULT_IN,
    input wire logic        FAULT_REPORT_N_OUT,
    input wire logic        OUTPUT_HIZ_OUT,
    input wire logic        AUTO_RECOVER_EN_OUT,
    input wire logic        CYCLE_LIMIT_FUNC_EN_OUT,
    input wire logic        IRQ_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    ack_one_cycle_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT
        && CE_IN |=> WB_ACK_OUT) else $error("request not acked");
    ack_cause_a: assert property ($rose(WB_ACK_OUT) |->
        $past(WB_CYC_IN && WB_STB_IN)) else $error("ack without request");
    upper_data_a: assert property (WB_ACK_OUT |->
        WB_DAT_OUT[31:8] == 24'h00_0000) else $error("upper data set");
    data_hold_a: assert property ($changed(WB_DAT_OUT) |-> WB_ACK_OUT)
        else $error("read data moved outside ack");
    hiz_fault_a: assert property (
        (OVERTEMP_SHUTDOWN_IN || CLOCK_FAULT_IN) [*6] |-> OUTPUT_HIZ_OUT)
        else $error("output stage not released on fault");
    quiet_reset_a: assert property ($rose(ARST_N_IN) |->
        FAULT_REPORT_N_OUT && !OUTPUT_HIZ_OUT && !IRQ_OUT)
        else $error("outputs not quiet after reset");
    autorec_write_a: assert property ($changed(AUTO_RECOVER_EN_OUT) |->
        WB_ACK_OUT || $past(WB_ACK_OUT) || $past(WB_ACK_OUT, 2))
        else $error("auto recover moved without write");
    func_write_a: assert property ($changed(CYCLE_LIMIT_FUNC_EN_OUT) |->
        WB_ACK_OUT || $past(WB_ACK_OUT) || $past(WB_ACK_OUT, 2))
        else $error("limit enable moved without write");
    irq_fall_a: assert property ($fell(IRQ_OUT) |-> WB_ACK_OUT ||
        $past(WB_ACK_OUT) || $past(WB_ACK_OUT, 2) || $past(WB_ACK_OUT, 3))
        else $error("irq dropped without access");
endmodule
bind fwrc_top fwrc_chk chk_u (
    .SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .CE_IN(CE_IN),
    .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
    .WB_ACK_OUT(WB_ACK_OUT), .WB_DAT_OUT(WB_DAT_OUT),
    .OVERTEMP_SHUTDOWN_IN(OVERTEMP_SHUTDOWN_IN),
    .CLOCK_FAULT_IN(CLOCK_FAULT_IN),
    .FAULT_REPORT_N_OUT(FAULT_REPORT_N_OUT),
    .OUTPUT_HIZ_OUT(OUTPUT_HIZ_OUT),
    .AUTO_RECOVER_EN_OUT(AUTO_RECOVER_EN_OUT),
    .CYCLE_LIMIT_FUNC_EN_OUT(CYCLE_LIMIT_FUNC_EN_OUT), .IRQ_OUT(IRQ_OUT)
);

/* File: verification/fwrc_host_mon.sv */
// host controller model: counts reports seen on the fault pin
// assumes: pin sampled on the device clock, reset with the device
`timescale 1ns/1ps
module fwrc_host_mon (
    input  wire logic       clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       fault_n_in,
    output logic [7:0]      report_cnt_out
);
    logic prev;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prev           <= 1'b1;
            report_cnt_out <= 8'h00;
        end else begin
            prev <= fault_n_in;
            // a falling edge is one new report
            if (prev && !fault_n_in) begin
                report_cnt_out <= report_cnt_out + 8'h01;
            end
        end
    end
endmodule

/* File: verification/tb.sv */
// self-checking bench of the fault and warning report controller
// assumes: checker bound to fwrc_top, host model on the fault pin
`timescale 1ns/1ps
module tb;
    import fwrc_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  sel  = 4'h0;
    logic [9:0]  adr  = 10'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [9:0]  flt  = 10'h000;
    logic [5:0]  wrn  = 6'h00;
    logic        ce   = 1'b1;
    logic        ack, rpt_n, hiz, det, arec, func, irq;
    logic [31:0] rdat;
    logic [7:0]  rcnt;
    int          error_cnt = 0;
    int          total_checks = 0;
    always #12.5 clk = ~clk;
    fwrc_top dut_u (
        .SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(ce),
        .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_SEL_IN(sel), .WB_ADR_IN(adr), .WB_DAT_IN(wdat),
        .LEFT_CYCLE_LIMIT_WARN_IN(wrn[5]), .RIGHT_CYCLE_LIMIT_WARN_IN(wrn[4]),
        .TEMP_WARN_LEVEL_IN(wrn[3:0]), .OVERTEMP_SHUTDOWN_IN(flt[0]),
        .DIGITAL_SUPPLY_UNDER_IN(flt[1]), .DIGITAL_SUPPLY_OVER_IN(flt[2]),
        .POWER_SUPPLY_UNDER_IN(flt[3]), .POWER_SUPPLY_OVER_IN(flt[4]),
        .CLOCK_FAULT_IN(flt[5]), .DC_FAULT_IN(flt[6]),
        .OVERCURRENT_IN(flt[7]), .CYCLE_LIMIT_FAULT_IN(flt[8]),
        .CLOCK_DETECT_IN(flt[9]), .WB_ACK_OUT(ack), .WB_DAT_OUT(rdat),
        .FAULT_REPORT_N_OUT(rpt_n), .OUTPUT_HIZ_OUT(hiz),
        .CLOCK_DETECT_STATUS_OUT(det), .AUTO_RECOVER_EN_OUT(arec),
        .CYCLE_LIMIT_FUNC_EN_OUT(func), .IRQ_OUT(irq)
    );
    fwrc_host_mon host_u (.clk_in(clk), .arst_n_in(rst_n),
        .fault_n_in(rpt_n), .report_cnt_out(rcnt));
    // fixed waits cover 2 sync stages, status and output flops
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] s,
        input logic [7:0] i, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= wr;
        sel  <= s;
        adr  <= {i, 2'b00};
        wdat <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            test_done();
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, 4'h1, i, d, q);
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, 4'h1, i, 8'h00, q);
        chk(q, e);
    endtask
    task automatic t_regs;
        logic [7:0] ix [8] = '{FWRC_IDX_WARN, FWRC_IDX_MASK1, FWRC_IDX_MASK2,
            FWRC_IDX_MISC, FWRC_IDX_CBC, FWRC_IDX_CLEAR, FWRC_IDX_IRQ_MSK,
            8'h90};
        logic [7:0] ex [8] = '{8'h00, 8'h00, 8'hf8, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00};
        logic [7:0] q;
        for (int k = 0; k < 8; k++) rd(ix[k], ex[k]);
        wr(FWRC_IDX_MASK1, 8'hff);
        rd(FWRC_IDX_MASK1, 8'hf7);
        wr(FWRC_IDX_MASK1, 8'h00);
        wr(FWRC_IDX_MISC, 8'h10);
        wr(FWRC_IDX_CBC, 8'h04);
        // lane 0 disabled: acked but ignored
        bus(1'b1, 4'h0, FWRC_IDX_MISC, 8'h00, q);
        wr(8'h90, 8'hff);
        w(2);
        rd(FWRC_IDX_MISC, 8'h10);
        chk({7'h0, arec}, 8'h01);
        chk({7'h0, func}, 8'h01);
        rd(8'h90, 8'h00);
        wr(FWRC_IDX_MISC, 8'h00);
        wr(FWRC_IDX_CBC, 8'h00);
        $display("regs test done");
    endtask
    task automatic t_warn;
        wr(FWRC_IDX_CBC, 8'h02);
        for (int p = 0; p < 2; p++) begin
            wr(FWRC_IDX_MASK2, p == 1 ? 8'h36 : 8'hf8);
            for (int j = 0; j < 6; j++) begin
                wrn[j] <= 1'b1;
                w(6);
                rd(FWRC_IDX_WARN, 8'h01 << j);
                chk({7'h0, rpt_n}, 8'(p));
                wrn[j] <= 1'b0;
                w(6);
                rd(FWRC_IDX_WARN, p == 1 ? 8'h00 : 8'h01 << j);
                wr(FWRC_IDX_CLEAR, 8'h80);
                w(2);
                rd(FWRC_IDX_WARN, 8'h00);
            end
        end
        wr(FWRC_IDX_MASK2, 8'hf8);
        wr(FWRC_IDX_CBC, 8'h00);
        $display("warning test done");
    endtask
    task automatic t_mask;
        int m [8] = '{7, 6, 5, 2, 2, 4, 1, 0};
        logic [7:0] lat [8] = '{8'h20, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
            8'h00, 8'h00};
        logic [7:0] c0;
        c0 = rcnt;
        for (int i = 0; i < 8; i++) begin
            for (int u = 0; u < 2; u++) begin
                wr(FWRC_IDX_MASK1, u == 1 ? 8'h00 : 8'h01 << m[i]);
                flt[i] <= 1'b1;
                w(6);
                chk({7'h0, rpt_n}, 8'(1 - u));
                chk({7'h0, hiz}, 8'(i != 6));
                flt[i] <= 1'b0;
                w(6);
                rd(FWRC_IDX_FAULT, lat[i]);
                wr(FWRC_IDX_CLEAR, 8'h80);
                w(6);
                rd(FWRC_IDX_FAULT, 8'h00);
                chk({7'h0, rpt_n}, 8'h01);
            end
        end
        chk(rcnt - c0, 8'h08);
        $display("mask test done");
    endtask
    task automatic t_irq;
        logic [7:0] q;
        bus(1'b0, 4'h1, FWRC_IDX_IRQ_ST, 8'h00, q);
        for (int u = 0; u < 2; u++) begin
            wr(FWRC_IDX_IRQ_MSK, u == 1 ? 8'h00 : 8'h01);
            flt[1] <= 1'b1;
            w(6);
            chk({7'h0, irq}, 8'(1 - u));
            flt[1] <= 1'b0;
            w(4);
            wr(FWRC_IDX_CLEAR, 8'h80);
            w(6);
            rd(FWRC_IDX_IRQ_ST, 8'h01);
            w(2);
            rd(FWRC_IDX_IRQ_ST, 8'h00);
            chk({7'h0, irq}, 8'h00);
        end
        $display("irq test done");
    endtask
    task automatic t_misc;
        wr(FWRC_IDX_MISC, 8'h80);
        flt[9] <= 1'b1;
        w(6);
        flt[9] <= 1'b0;
        w(6);
        chk({7'h0, det}, 8'h01);
        wr(FWRC_IDX_MISC, 8'h00);
        w(6);
        chk({7'h0, det}, 8'h00);
        wr(FWRC_IDX_CBC, 8'h01);
        flt[8] <= 1'b1;
        w(6);
        chk({7'h0, rpt_n}, 8'h00);
        flt[8] <= 1'b0;
        w(6);
        rd(FWRC_IDX_FAULT, 8'h40);
        wr(FWRC_IDX_MASK2, 8'hf9);
        w(4);
        chk({7'h0, rpt_n}, 8'h01);
        wr(FWRC_IDX_MISC, 8'h10);
        flt[0] <= 1'b1;
        w(6);
        flt[0] <= 1'b0;
        w(6);
        rd(FWRC_IDX_FAULT, 8'h40);
        ce <= 1'b0;
        flt[1] <= 1'b1;
        w(6);
        chk({7'h0, rpt_n}, 8'h01);
        ce <= 1'b1;
        w(6);
        chk({7'h0, rpt_n}, 8'h00);
        // mid-run reset clears the latched limit fault, which clear bit 7 does not reach
        rst_n <= 1'b0;
        flt[1] <= 1'b0;
        w(2);
        rst_n <= 1'b1;
        rd(FWRC_IDX_FAULT, 8'h00);
        rd(FWRC_IDX_MASK2, 8'hf8);
        $display("misc test done");
    endtask
    initial begin
        w(4);
        rst_n <= 1'b1;
        t_regs();
        t_warn();
        t_mask();
        t_irq();
        t_misc();
        test_done();
    end
endmodule
